//--- rtl/pbbs_top.sv
// self-test beep and blink sequencer with progress code latch
`timescale 1ns/1ps
module pbbs_top #(
    parameter int HALF_CYC = pbbs_pkg::HALF_SEC_CYC,
    parameter int HI_HALF  = pbbs_pkg::TONE_HI_HALF,
    parameter int LO_HALF  = pbbs_pkg::TONE_LO_HALF
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        evt_valid,
    input  wire logic [pbbs_pkg::EVT_W-1:0]  evt_code,
    input  wire logic                        fw_update,
    input  wire logic                        io_wr,
    input  wire logic [15:0]                 io_addr,
    input  wire logic [pbbs_pkg::CODE_W-1:0] io_wdata,
    output logic                             spk_out,
    output logic                             led_out,
    output logic                             busy,
    output logic [pbbs_pkg::CODE_W-1:0]      post_code
);
    import pbbs_pkg::*;

    //--------------------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------------------
    // sequencer state and shared tick
    pbbs_state_t       state_r;
    logic [CNT_W-1:0]  half_cnt_r;
    logic              half_done;

    // event and update decode
    logic              evt_known;
    logic              evt_take;
    logic              upd_r;
    logic              upd_rise;
    logic              upd_fall;
    logic              start;

    // shape of the running pattern
    logic [2:0]        group_r;
    logic              hi_tone_r;
    logic              repeat_r;
    logic              limited_r;
    logic              led_inv_r;

    // position inside the pattern
    logic [2:0]        beep_cnt_r;
    logic [4:0]        total_cnt_r;
    logic [2:0]        pause_cnt_r;

    // outputs, pitch and progress latch
    logic              led_nxt;
    logic [CODE_W-1:0] code_r;
    logic              busy_r;
    logic              led_r;
    logic [CNT_W-1:0]  tone_half;
    logic              last_tone;

    //--------------------------------------------------------------------------
    // event decode
    //--------------------------------------------------------------------------

    // only the five defined codes start a pattern
    assign evt_known = (evt_code == EVT_CPU_DONE)
                    || (evt_code == EVT_POST_DONE)
                    || (evt_code == EVT_VIDEO_ERR)
                    || (evt_code == EVT_MEM_ERR)
                    || (evt_code == EVT_THERMAL);

    // events during a firmware update are ignored
    assign evt_take = evt_valid && evt_known && !fw_update;

    // update start and end edges
    assign upd_rise = fw_update && !upd_r;
    assign upd_fall = !fw_update && upd_r;

    // any start realigns timing for both outputs
    assign start = evt_take || upd_rise;

    // firmware update level history
    always_ff @(posedge clk) begin
        if (!resetn) begin
            upd_r <= 1'b0;
        end else begin
            upd_r <= fw_update;
        end
    end

    //--------------------------------------------------------------------------
    // shared half second tick
    //--------------------------------------------------------------------------

    assign half_done = (half_cnt_r == CNT_W'(HALF_CYC - 1));

    // one counter times every interval of every pattern
    always_ff @(posedge clk) begin
        if (!resetn || start || upd_fall) begin
            half_cnt_r <= '0;
        end else if (state_r == ST_IDLE || half_done) begin
            half_cnt_r <= '0;
        end else begin
            half_cnt_r <= half_cnt_r + 1'b1;
        end
    end

    //--------------------------------------------------------------------------
    // pattern selection
    //--------------------------------------------------------------------------

    // latch the shape of the pattern when an event is taken
    always_ff @(posedge clk) begin
        if (!resetn) begin
            group_r   <= 3'h1;
            hi_tone_r <= 1'b1;
            repeat_r  <= 1'b0;
            limited_r <= 1'b0;
            led_inv_r <= 1'b1;
        end else if (evt_take) begin
            case (evt_code)
                EVT_VIDEO_ERR: begin
                    group_r   <= VIDEO_BEEPS;
                    hi_tone_r <= 1'b1;
                    repeat_r  <= 1'b1;
                    limited_r <= 1'b0;
                    led_inv_r <= 1'b0;
                end
                EVT_MEM_ERR: begin
                    group_r   <= MEM_BEEPS;
                    hi_tone_r <= 1'b0;
                    repeat_r  <= 1'b1;
                    limited_r <= 1'b0;
                    led_inv_r <= 1'b0;
                end
                EVT_THERMAL: begin
                    group_r   <= THERM_BEEPS;
                    hi_tone_r <= 1'b0;
                    repeat_r  <= 1'b1;
                    limited_r <= 1'b1;
                    led_inv_r <= 1'b0;
                end
                default: begin
                    group_r   <= 3'h1;
                    hi_tone_r <= 1'b1;
                    repeat_r  <= 1'b0;
                    limited_r <= 1'b0;
                    led_inv_r <= 1'b1;
                end
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // sequencer
    //--------------------------------------------------------------------------

    // sixteenth tone of a limited pattern
    assign last_tone = limited_r && (total_cnt_r == THERM_TOTAL - 5'h01);

    // tones sounded since the event was taken
    always_ff @(posedge clk) begin
        if (!resetn || evt_take) begin
            total_cnt_r <= 5'h00;
        end else if (half_done && state_r == ST_BEEP) begin
            total_cnt_r <= total_cnt_r + 5'h01;
        end
    end

    // half seconds spent in the silent pause, cleared outside it
    always_ff @(posedge clk) begin
        if (!resetn || state_r != ST_PAUSE) begin
            pause_cnt_r <= 3'h0;
        end else if (half_done) begin
            pause_cnt_r <= pause_cnt_r + 3'h1;
        end
    end

    // beep, gap and pause stepping on half second ticks
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r    <= ST_IDLE;
            beep_cnt_r <= 3'h0;
        end else if (upd_rise) begin
            state_r <= ST_UPD_DARK;
        end else if (evt_take) begin
            // an event in the cycle an update ends is still taken
            state_r    <= ST_BEEP;
            beep_cnt_r <= 3'h0;
        end else if (upd_fall) begin
            state_r <= ST_IDLE;
        end else if (half_done) begin
            case (state_r)
                ST_BEEP: begin
                    if (last_tone) begin
                        state_r <= ST_IDLE;
                    end else if (!repeat_r) begin
                        state_r <= ST_IDLE;
                    end else begin
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (beep_cnt_r == group_r - 3'h1) begin
                        state_r <= ST_PAUSE;
                    end else begin
                        state_r    <= ST_BEEP;
                        beep_cnt_r <= beep_cnt_r + 3'h1;
                    end
                end
                ST_PAUSE: begin
                    if (pause_cnt_r == PAUSE_LAST) begin
                        state_r    <= ST_BEEP;
                        beep_cnt_r <= 3'h0;
                    end
                end
                ST_UPD_DARK: begin
                    state_r <= ST_UPD_LIT;
                end
                ST_UPD_LIT: begin
                    state_r <= ST_UPD_DARK;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // speaker
    //--------------------------------------------------------------------------

    // tone pitch by pattern
    assign tone_half = hi_tone_r ? CNT_W'(HI_HALF) : CNT_W'(LO_HALF);

    // square wave only during beep phases, never in update
    pbbs_tone_gen #(
        .CNT_W    (CNT_W)
    ) u_tone (
        .clk      (clk),
        .resetn   (resetn),
        .en       (state_r == ST_BEEP),
        .restart  (start),
        .half_cyc (tone_half),
        .tone_r   (spk_out)
    );

    //--------------------------------------------------------------------------
    // power LED
    //--------------------------------------------------------------------------

    // LED level by phase
    always_comb begin
        case (state_r)
            ST_IDLE:     led_nxt = 1'b1;
            ST_BEEP:     led_nxt = !led_inv_r;
            ST_GAP:      led_nxt = 1'b0;
            ST_PAUSE:    led_nxt = 1'b0;
            ST_UPD_DARK: led_nxt = 1'b0;
            ST_UPD_LIT:  led_nxt = 1'b1;
            default:     led_nxt = 1'b1;
        endcase
    end

    // registered so LED and tone change on the same edge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            led_r <= 1'b1;
        end else begin
            led_r <= led_nxt;
        end
    end

    // pattern running flag, one cycle behind the sequencer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_r != ST_IDLE);
        end
    end

    // registered values straight to the pins
    assign led_out = led_r;
    assign busy    = busy_r;

    //--------------------------------------------------------------------------
    // progress code latch
    //--------------------------------------------------------------------------

    // keep the last byte written to the progress port
    always_ff @(posedge clk) begin
        if (!resetn) begin
            code_r <= CODE_RESET;
        end else if (io_wr && io_addr == CODE_PORT) begin
            code_r <= io_wdata;
        end
    end

    // held byte for the monitor card on the far side
    assign post_code = code_r;

endmodule // pbbs_top

//--- rtl/pbbs_pkg.sv
// constants and encodings for the self-test beep and blink signaller
//------------------------------------------------------------------------------
// Notes on behaviour
// - a reported recoverable error plays a speaker pattern and an LED pattern by type
// - processor init done sounds exactly one 0.5 s tone at 3270 Hz
// - self-test complete sounds one 0.5 s tone at 3270 Hz
// - video error: two 0.5 s on/off beeps at 3270 Hz, then 3.0 s pause
// - firmware reports a missing video option firmware as the video error event
// - memory error: three 0.5 s on/off beeps at 1280 Hz, then 3.0 s pause
// - video and memory patterns repeat with their pauses until power is removed; here a newly taken event or an update start ends them
// - thermal warning: groups of four 0.5 s beeps at 1280 Hz, 3.0 s pauses
// - thermal pattern stops by itself after the sixteenth tone
// - init done and self-test done: LED lit, then dark for 0.5 s
// - during firmware update speaker silent, LED dark first, then 0.5 s on/off alternation
// - video and memory LED: two or three blinks, 3.0 s dark pause, repeating
// - thermal LED: groups of four blinks, 3.0 s pauses, ends after sixteenth blink
// - the last progress code written to port 80h is held and readable
// - progress codes are eight-bit values 00 to FF, so the latch is eight bits
//------------------------------------------------------------------------------
package pbbs_pkg;

    //--------------------------------------------------------------------------
    // clock and timing
    //--------------------------------------------------------------------------
    localparam int CLK_HZ         = 100_000_000;
    localparam int HALF_SEC_MS    = 500;
    localparam int PAUSE_MS       = 3000;
    localparam int TONE_HI_HZ     = 3270;
    localparam int TONE_LO_HZ     = 1280;
    localparam int HALF_SEC_CYC   = (CLK_HZ / 1000) * HALF_SEC_MS;
    localparam int PAUSE_HALVES   = PAUSE_MS / HALF_SEC_MS;
    localparam int TONE_HI_HALF   = CLK_HZ / (2 * TONE_HI_HZ);
    localparam int TONE_LO_HALF   = CLK_HZ / (2 * TONE_LO_HZ);
    localparam int CNT_W          = 26;

    //--------------------------------------------------------------------------
    // pattern shapes
    //--------------------------------------------------------------------------
    localparam logic [2:0] VIDEO_BEEPS   = 3'h2;
    localparam logic [2:0] MEM_BEEPS     = 3'h3;
    localparam logic [2:0] THERM_BEEPS   = 3'h4;
    localparam logic [4:0] THERM_TOTAL   = 5'h10;
    localparam logic [2:0] PAUSE_LAST    = 3'(PAUSE_HALVES - 1);

    //--------------------------------------------------------------------------
    // event codes and progress port
    //--------------------------------------------------------------------------
    localparam int         EVT_W         = 3;
    localparam logic [2:0] EVT_CPU_DONE  = 3'h0;
    localparam logic [2:0] EVT_POST_DONE = 3'h1;
    localparam logic [2:0] EVT_VIDEO_ERR = 3'h2;
    localparam logic [2:0] EVT_MEM_ERR   = 3'h3;
    localparam logic [2:0] EVT_THERMAL   = 3'h4;
    localparam int          CODE_W       = 8;
    localparam logic [15:0] CODE_PORT    = 16'h0080;
    localparam logic [7:0]  CODE_RESET   = 8'h00;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BEEP,
        ST_GAP,
        ST_PAUSE,
        ST_UPD_DARK,
        ST_UPD_LIT
    } pbbs_state_t;

endpackage

//--- rtl/pbbs_tone_gen.sv
// square wave tone divider for the speaker
`timescale 1ns/1ps
module pbbs_tone_gen #(
    parameter int CNT_W = pbbs_pkg::CNT_W
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             en,
    input  wire logic             restart,
    input  wire logic [CNT_W-1:0] half_cyc,
    output logic                  tone_r
);
    import pbbs_pkg::*;

    logic [CNT_W-1:0] div_r;

    //--------------------------------------------------------------------------
    // divider: toggles every half period while enabled
    //--------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn || !en || restart) begin
            div_r  <= '0;
            tone_r <= 1'b0;
        end else if (div_r == half_cyc - 1'b1) begin
            div_r  <= '0;
            tone_r <= ~tone_r;
        end else begin
            div_r  <= div_r + 1'b1;
        end
    end

endmodule // pbbs_tone_gen

//--- test/pbbs_host_model.sv
// host firmware model: reports self-test events, progress codes and updates
`timescale 1ns/1ps
module pbbs_host_model (
    input  wire logic                   clk,
    output logic                        evt_valid,
    output logic [pbbs_pkg::EVT_W-1:0]  evt_code,
    output logic                        fw_update,
    output logic                        io_wr,
    output logic [15:0]                 io_addr,
    output logic [pbbs_pkg::CODE_W-1:0] io_wdata
);
    import pbbs_pkg::*;
    // quiet bus from time zero
    initial begin
        evt_valid = 1'b0;
        evt_code  = 3'h7;
        fw_update = 1'b0;
        io_wr     = 1'b0;
        io_addr   = 16'hFFFF;
        io_wdata  = 8'h00;
    end
    // one-cycle event strobe; a missing video option firmware goes out as the video code
    task automatic post_event(input logic [EVT_W-1:0] code);
        @(posedge clk);
        evt_valid <= 1'b1;
        evt_code  <= code;
        @(posedge clk);
        evt_valid <= 1'b0;
        evt_code  <= ~code;
    endtask
    // one byte progress write, inverted lines once released
    task automatic port_write(input logic [15:0] addr, input logic [CODE_W-1:0] data);
        @(posedge clk);
        io_wr    <= 1'b1;
        io_addr  <= addr;
        io_wdata <= data;
        @(posedge clk);
        io_wr    <= 1'b0;
        io_addr  <= ~addr;
        io_wdata <= ~data;
    endtask
    // update in progress level
    task automatic set_update(input logic on);
        @(posedge clk);
        fw_update <= on;
    endtask
endmodule // pbbs_host_model

//--- test/pbbs_top_sva.sv
// port assertions for the self-test beep and blink signaller
`timescale 1ns/1ps
module pbbs_top_sva #(
    parameter int HALF_CYC = 40,
    parameter int HI_HALF  = 3,
    parameter int LO_HALF  = 5
) (
    input wire logic                        clk,
    input wire logic                        resetn,
    input wire logic                        evt_valid,
    input wire logic [pbbs_pkg::EVT_W-1:0]  evt_code,
    input wire logic                        fw_update,
    input wire logic                        io_wr,
    input wire logic [15:0]                 io_addr,
    input wire logic [pbbs_pkg::CODE_W-1:0] io_wdata,
    input wire logic                        spk_out,
    input wire logic                        led_out,
    input wire logic                        busy,
    input wire logic [pbbs_pkg::CODE_W-1:0] post_code
);
    import pbbs_pkg::*;
    //--------------------------------------------------------------------------
    // behaviour at the ports
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_code_latch: assert property (io_wr && io_addr == CODE_PORT |=> post_code == $past(io_wdata))
        else $error("progress code not captured");
    chk_code_hold: assert property (!(io_wr && io_addr == CODE_PORT) |=> $stable(post_code))
        else $error("progress code changed without a port write");
    chk_event_busy: assert property (evt_valid && evt_code <= EVT_THERMAL && !fw_update |-> ##[1:2] busy)
        else $error("event did not start a pattern");
    chk_bad_code: assert property (evt_valid && evt_code > EVT_THERMAL && !busy && !fw_update |=> ##1 !busy)
        else $error("unknown event code started a pattern");
    chk_single_dark: assert property (evt_valid && evt_code <= EVT_POST_DONE && !fw_update |-> ##2 (!led_out)[*8])
        else $error("single event did not dim the lamp");
    chk_err_lit: assert property (evt_valid && (evt_code == EVT_VIDEO_ERR || evt_code == EVT_MEM_ERR)
        && !fw_update |-> ##2 led_out[*8])
        else $error("error pattern did not open with a lit blink");
    chk_upd_dark: assert property ($rose(fw_update) |-> ##3 (!led_out)[*8])
        else $error("update did not start dark");
    chk_upd_quiet: assert property (fw_update[*3] |-> !spk_out)
        else $error("speaker sounded during update");
    chk_idle_state: assert property (!busy[*3] |-> !spk_out && led_out)
        else $error("idle outputs wrong");
endmodule // pbbs_top_sva

//--- test/testbench.sv
// self-checking bench for the self-test beep and blink signaller
`timescale 1ns/1ps
module testbench;
    import pbbs_pkg::*;
    localparam int HALF = 40;
    localparam int HI   = 3;
    localparam int LO   = 5;
    logic              clk;
    logic              resetn;
    logic              evt_valid;
    logic [EVT_W-1:0]  evt_code;
    logic              fw_update;
    logic              io_wr;
    logic [15:0]       io_addr;
    logic [CODE_W-1:0] io_wdata;
    logic              spk_out;
    logic              led_out;
    logic              busy;
    logic [CODE_W-1:0] post_code;
    int                errors;
    int                compares;
    int                lit;
    int                falls;
    int                hi_max;
    int                bad;
    int                rises;

    pbbs_top #(.HALF_CYC(HALF), .HI_HALF(HI), .LO_HALF(LO)) u_dut (.clk(clk), .resetn(resetn),
        .evt_valid(evt_valid), .evt_code(evt_code), .fw_update(fw_update), .io_wr(io_wr), .io_addr(io_addr),
        .io_wdata(io_wdata), .spk_out(spk_out), .led_out(led_out), .busy(busy), .post_code(post_code));
    pbbs_host_model u_host (.clk(clk), .evt_valid(evt_valid), .evt_code(evt_code), .fw_update(fw_update),
        .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata));

    //--------------------------------------------------------------------------
    // clock, compare and closing
    //--------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // count lit cycles, lamp falls, longest tone high run, tone while dark, tone rises
    task automatic watch(input int n);
        logic led_p;
        logic spk_p;
        int   run;
        {lit, falls, hi_max, bad, rises, run} = '0;
        led_p = led_out;
        spk_p = spk_out;
        repeat (n) begin
            @(posedge clk);
            #1;
            lit += int'(led_out);
            falls += int'(led_p && !led_out);
            rises += int'(!spk_p && spk_out);
            bad += int'(spk_out && !led_out && !led_p);
            run = spk_out ? run + 1 : 0;
            if (run > hi_max) hi_max = run;
            led_p = led_out;
            spk_p = spk_out;
        end
    endtask

    //--------------------------------------------------------------------------
    // scenarios
    //--------------------------------------------------------------------------
    task automatic t_reset;
        check("spk_out", spk_out, 0);
        check("led_out", led_out, 1);
        check("busy", busy, 0);
        check("post_code", post_code, CODE_RESET);
        $display("end of reset test");
    endtask
    task automatic t_port;
        u_host.port_write(CODE_PORT, 8'hFF);
        @(posedge clk);
        #1;
        check("post_code", post_code, 8'hFF);
        u_host.port_write(16'h0081, 8'h3C);
        u_host.port_write(16'h0180, 8'h3C);
        @(posedge clk);
        #1;
        check("post_code", post_code, 8'hFF);
        u_host.port_write(CODE_PORT, 8'h00);
        u_host.port_write(CODE_PORT, 8'hA5);
        @(posedge clk);
        #1;
        check("post_code", post_code, 8'hA5);
        $display("end of port test");
    endtask
    task automatic t_invalid;
        for (int c = 5; c < 8; c++) begin
            u_host.post_event(3'(c));
            repeat (3) @(posedge clk);
            #1;
            check("busy", busy, 0);
        end
        $display("end of unknown code test");
    endtask
    task automatic t_single;
        for (int c = 0; c < 2; c++) begin
            u_host.post_event(3'(c));
            watch(200);
            check("dark cycles", 200 - lit, HALF);
            check("lamp falls", falls, 1);
            check("tone half", hi_max, HI);
            check("busy", busy, 0);
        end
        $display("end of single beep test");
    endtask
    task automatic t_video;
        u_host.post_event(EVT_MEM_ERR);
        repeat (200) @(posedge clk);
        u_host.post_event(EVT_VIDEO_ERR);
        watch(800);
        check("lit cycles", lit, 4 * HALF);
        check("lamp falls", falls, 4);
        check("tone half", hi_max, HI);
        check("tone in dark", bad, 0);
        check("tone present", rises > 0, 1);
        $display("end of video test");
    endtask
    task automatic t_update;
        u_host.set_update(1'b1);
        u_host.post_event(EVT_MEM_ERR);
        watch(800);
        check("lit cycles", lit, 400);
        check("tone rises", rises, 0);
        u_host.set_update(1'b0);
        repeat (4) @(posedge clk);
        #1;
        check("busy", busy, 0);
        check("led_out", led_out, 1);
        $display("end of update test");
    endtask
    task automatic t_memory;
        u_host.post_event(EVT_MEM_ERR);
        watch(960);
        check("lit cycles", lit, 6 * HALF);
        check("lamp falls", falls, 6);
        check("tone half", hi_max, LO);
        check("tone in dark", bad, 0);
        $display("end of memory test");
    endtask
    task automatic t_thermal;
        u_host.post_event(EVT_THERMAL);
        watch(2300);
        check("lamp falls", falls, 15);
        check("tone half", hi_max, LO);
        check("tone in dark", bad, 0);
        check("busy", busy, 0);
        check("led_out", led_out, 1);
        watch(100);
        check("tone rises", rises, 0);
        $display("end of thermal test");
    endtask

    //--------------------------------------------------------------------------
    // main sequence and watchdog
    //--------------------------------------------------------------------------
    initial begin
        errors = 0;
        compares = 0;
        resetn = 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        t_reset;
        t_port;
        t_invalid;
        t_single;
        t_video;
        t_update;
        t_memory;
        t_thermal;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        wrap_up;
    end
endmodule // testbench

bind pbbs_top pbbs_top_sva #(.HALF_CYC(HALF_CYC), .HI_HALF(HI_HALF), .LO_HALF(LO_HALF)) u_sva (.clk(clk),
    .resetn(resetn), .evt_valid(evt_valid), .evt_code(evt_code), .fw_update(fw_update), .io_wr(io_wr),
    .io_addr(io_addr), .io_wdata(io_wdata), .spk_out(spk_out), .led_out(led_out), .busy(busy),
    .post_code(post_code));
